/* rtl/ext_bus_pkg.sv */
// Constants and carrier types for the external memory bus sequencer
package ext_bus_pkg;

  localparam int unsigned CLK_PERIOD_NS    = 100;
  localparam int unsigned OSC_PER_STATE    = 2;
  localparam int unsigned STATES_PER_CYCLE = 6;
  localparam int unsigned OSC_PER_CYCLE    = OSC_PER_STATE * STATES_PER_CYCLE;
  localparam int unsigned SLOT_LEN         = 6;

  localparam logic [3:0]  CNT_RESET   = 4'h0;
  localparam logic [3:0]  CNT_LAST    = 4'(OSC_PER_CYCLE - 1);
  localparam logic [3:0]  SLOT_SPLIT  = 4'(SLOT_LEN);
  localparam logic [2:0]  PH_FIRST    = 3'h0;
  localparam logic [2:0]  PH_ALE_END  = 3'h1;
  localparam logic [2:0]  PH_ADDR_END = 3'h2;
  localparam logic [2:0]  PH_STB_BEG  = 3'h3;
  localparam logic [2:0]  PH_SAMPLE   = 3'h4;
  localparam logic [2:0]  PH_LAST     = 3'h5;

  localparam logic [15:0] INT_ROM_TOP = 16'h3FFF;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [7:0]  BYTE_ONES   = 8'hFF;
  localparam logic [15:0] ADDR_RESET  = 16'h0000;

  typedef enum logic [2:0] {
    SLOT_IO,
    SLOT_INT_FETCH,
    SLOT_FETCH,
    SLOT_DATA1,
    SLOT_DATA2
  } slot_kind_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        wide;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } data_req_t;

  typedef struct packed {
    logic       done;
    logic [7:0] rdata;
  } data_resp_t;

  typedef struct packed {
    logic       done;
    logic       ext;
    logic [7:0] code;
  } fetch_resp_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pad8_t;

endpackage

/* rtl/ext_bus_seq.sv */
// Machine-cycle sequencer and multiplexed external memory bus
// Operation
// RL1: Machine cycle is six states of two clocks each, twelve clocks total.
// RL2: Address-latch strobe pulses every six clocks, without pause.
// RL3: External latch captures low address byte on the address-latch strobe.
// RL4: External code execution gives two program-fetch strobes per machine cycle.
// RL5: An external data access replaces two consecutive program-fetch strobes.
// RL6: Select high: fetch internally up to 3FFF, externally above.
// RL7: Select low: every fetch goes to external memory.
// RL8: Low bus carries low address first, then the data byte.
// RL9: Address or data ones on the low bus are actively driven high.
// RL10: As plain I/O, a low-bus bit with latch one is left floating.
// RL11: Idle halts fetching and data access; timing keeps running.
// RL12: Power-down freezes the sequencer; all bus activity stops.
// RL13: Sixteen-bit accesses drive the high address byte on the high bus.
// RL14: Eight-bit data accesses keep the high port latch on the high bus.
// RL15: The low bus floats during the data phase of an external read.
`timescale 1ns/100ps
module ext_bus_seq (
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_i,
  input  wire logic                     external_access_select_i,
  input  wire logic                     idle_i,
  input  wire logic                     power_down_i,
  input  wire logic [15:0]              pc_i,
  input  wire ext_bus_pkg::data_req_t   data_req_i,
  input  wire logic [7:0]               low_port_latch_i,
  input  wire logic [7:0]               high_address_port_latch_i,
  input  wire logic [7:0]               low_address_data_bus_i,
  output logic [7:0]                    low_address_data_bus_o,
  output logic [7:0]                    low_address_data_bus_oe_o,
  output logic [7:0]                    high_address_bus_o,
  output logic                          ale_o,
  output logic                          program_fetch_strobe_n_o,
  output logic                          ext_read_n_o,
  output logic                          ext_write_n_o,
  output logic [2:0]                    state_idx_o,
  output ext_bus_pkg::fetch_resp_t      fetch_resp_o,
  output ext_bus_pkg::data_resp_t       data_resp_o
);

  logic [3:0]                cnt_ff, nxt_cnt;
  ext_bus_pkg::slot_kind_t   kind_ff, nxt_kind;
  ext_bus_pkg::data_req_t    acc_ff, nxt_acc;
  logic [2:0]                ph, nph, nxt_state_idx;
  logic                      ext_code;
  ext_bus_pkg::pad8_t        nxt_pad;
  logic [7:0]                nxt_high;
  logic                      nxt_ale, nxt_fetch_stb_n, nxt_rd_n, nxt_wr_n;
  ext_bus_pkg::fetch_resp_t  nxt_fetch;
  ext_bus_pkg::data_resp_t   nxt_data;

  // Sequencer: cycle counter, slot kind and captured access
  always_comb begin
    ph = (cnt_ff >= ext_bus_pkg::SLOT_SPLIT) ? 3'(cnt_ff - ext_bus_pkg::SLOT_SPLIT)
                                             : cnt_ff[2:0];
    ext_code = !external_access_select_i || (pc_i > ext_bus_pkg::INT_ROM_TOP); // see RL6 RL7
    nxt_kind = kind_ff;
    nxt_acc  = acc_ff;
    // Oscillator stopped: nothing advances in power-down
    if (power_down_i) begin
      nxt_cnt = cnt_ff; // see RL12
    end else if (cnt_ff == ext_bus_pkg::CNT_LAST) begin
      nxt_cnt = ext_bus_pkg::CNT_RESET; // see RL1
    end else begin
      nxt_cnt = cnt_ff + 4'h1;
    end
    nph = (nxt_cnt >= ext_bus_pkg::SLOT_SPLIT) ? 3'(nxt_cnt - ext_bus_pkg::SLOT_SPLIT)
                                               : nxt_cnt[2:0];
    nxt_state_idx = 3'(nxt_cnt >> 1); // see RL1
    if (!power_down_i && nph == ext_bus_pkg::PH_FIRST) begin
      // A data access owns two slots, so two fetch strobes are skipped
      // Right after a data access a fetch slot follows (an I/O slot when idle), giving the core time to drop its request
      if (kind_ff == ext_bus_pkg::SLOT_DATA1) begin
        nxt_kind = ext_bus_pkg::SLOT_DATA2; // see RL5
      end else if (idle_i) begin
        nxt_kind = ext_bus_pkg::SLOT_IO; // see RL11
      end else if (data_req_i.valid && kind_ff != ext_bus_pkg::SLOT_DATA2) begin
        nxt_kind = ext_bus_pkg::SLOT_DATA1; // see RL5
        nxt_acc  = data_req_i;
      end else if (ext_code) begin
        nxt_kind      = ext_bus_pkg::SLOT_FETCH; // see RL4
        nxt_acc.addr  = pc_i;
        nxt_acc.wide  = 1'b1;
        nxt_acc.write = 1'b0;
      end else begin
        nxt_kind     = ext_bus_pkg::SLOT_INT_FETCH;
        nxt_acc.addr = pc_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_ff  <= ext_bus_pkg::CNT_RESET;
      kind_ff <= ext_bus_pkg::SLOT_IO;
      acc_ff  <= '0;
    end else begin
      cnt_ff  <= nxt_cnt;
      kind_ff <= nxt_kind;
      acc_ff  <= nxt_acc;
    end
  end

  // Pin drive, computed for the next phase so every pin leaves a flip-flop
  always_comb begin
    nxt_ale         = !power_down_i && (nph <= ext_bus_pkg::PH_ALE_END); // see RL2
    nxt_fetch_stb_n = 1'b1;
    nxt_rd_n        = 1'b1;
    nxt_wr_n        = 1'b1;
    nxt_pad.out = ext_bus_pkg::BYTE_ZERO;
    nxt_pad.oe  = ~low_port_latch_i; // see RL10
    nxt_high    = high_address_port_latch_i;
    if (!power_down_i) begin
      case (nxt_kind)
        ext_bus_pkg::SLOT_FETCH, ext_bus_pkg::SLOT_DATA1, ext_bus_pkg::SLOT_DATA2: begin
          if (nxt_acc.wide) begin
            nxt_high = nxt_acc.addr[15:8]; // see RL13
          end else begin
            nxt_high = high_address_port_latch_i; // see RL14
          end
          // Address stays one phase past the strobe so the latch hold time is met
          if (nph <= ext_bus_pkg::PH_ADDR_END) begin
            nxt_pad.out = nxt_acc.addr[7:0]; // see RL8 RL3
            nxt_pad.oe  = ext_bus_pkg::BYTE_ONES; // see RL9
          end else if (nxt_kind == ext_bus_pkg::SLOT_DATA2 && nph <= ext_bus_pkg::PH_SAMPLE
                       && nxt_acc.write) begin
            nxt_pad.out = nxt_acc.wdata; // see RL8
            nxt_pad.oe  = ext_bus_pkg::BYTE_ONES; // see RL9
          end else begin
            nxt_pad.oe  = ext_bus_pkg::BYTE_ZERO; // see RL15
          end
          if (nph >= ext_bus_pkg::PH_STB_BEG && nph <= ext_bus_pkg::PH_SAMPLE) begin
            if (nxt_kind == ext_bus_pkg::SLOT_FETCH) begin
              nxt_fetch_stb_n = 1'b0; // see RL4
            end else if (nxt_kind == ext_bus_pkg::SLOT_DATA2) begin
              nxt_rd_n = nxt_acc.write;
              nxt_wr_n = !nxt_acc.write;
            end
          end
        end
        default: begin
        end
      endcase
    end
    nxt_fetch.done = !power_down_i && ph == ext_bus_pkg::PH_SAMPLE &&
                     (kind_ff == ext_bus_pkg::SLOT_FETCH ||
                      kind_ff == ext_bus_pkg::SLOT_INT_FETCH);
    nxt_fetch.ext  = (kind_ff == ext_bus_pkg::SLOT_FETCH);
    nxt_fetch.code = low_address_data_bus_i;
    nxt_data.done  = !power_down_i && ph == ext_bus_pkg::PH_SAMPLE &&
                     kind_ff == ext_bus_pkg::SLOT_DATA2;
    nxt_data.rdata = low_address_data_bus_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      low_address_data_bus_o    <= ext_bus_pkg::BYTE_ZERO;
      low_address_data_bus_oe_o <= ext_bus_pkg::BYTE_ZERO;
      high_address_bus_o        <= ext_bus_pkg::BYTE_ZERO;
      ale_o                     <= 1'b0;
      program_fetch_strobe_n_o  <= 1'b1;
      ext_read_n_o              <= 1'b1;
      ext_write_n_o             <= 1'b1;
      state_idx_o               <= 3'h0;
      fetch_resp_o              <= '0;
      data_resp_o               <= '0;
    end else begin
      low_address_data_bus_o    <= nxt_pad.out;
      low_address_data_bus_oe_o <= nxt_pad.oe;
      high_address_bus_o        <= nxt_high;
      ale_o                     <= nxt_ale;
      program_fetch_strobe_n_o  <= nxt_fetch_stb_n;
      ext_read_n_o              <= nxt_rd_n;
      ext_write_n_o             <= nxt_wr_n;
      state_idx_o               <= nxt_state_idx;
      fetch_resp_o              <= nxt_fetch;
      data_resp_o               <= nxt_data;
    end
  end

  sequence s_run5;
    !power_down_i [*5];
  endsequence

  property p_cycle_len;
    @(posedge clk_sys_i) disable iff (rst_i)
      (cnt_ff == ext_bus_pkg::CNT_RESET && !power_down_i) ##1 s_run5 ##1 s_run5 ##1
      !power_down_i |=> cnt_ff == ext_bus_pkg::CNT_RESET;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("cycle not twelve clocks"); // see RL1

  property p_ale_period;
    @(posedge clk_sys_i) disable iff (rst_i)
      // First pulse after reset or power-down may be cut short, so only full pulses start
      ($rose(ale_o) && ph == ext_bus_pkg::PH_FIRST && !power_down_i) ##1 s_run5
      |=> $rose(ale_o);
  endproperty
  a_ale_period: assert property (p_ale_period) else $error("latch strobe not every six"); // see RL2

  property p_fetch_strobe;
    @(posedge clk_sys_i) disable iff (rst_i)
      (fetch_resp_o.done && fetch_resp_o.ext) |->
      $past(!program_fetch_strobe_n_o, 1) && $past(!program_fetch_strobe_n_o, 2);
  endproperty
  a_fetch_strobe: assert property (p_fetch_strobe) else $error("fetch without strobe"); // see RL4

  property p_data_skip;
    @(posedge clk_sys_i) disable iff (rst_i || power_down_i)
      (kind_ff == ext_bus_pkg::SLOT_DATA1 && ph == ext_bus_pkg::PH_FIRST) |->
      program_fetch_strobe_n_o [*6] ##1 program_fetch_strobe_n_o [*6];
  endproperty
  a_data_skip: assert property (p_data_skip) else $error("strobe during data access"); // see RL5

  property p_int_fetch;
    @(posedge clk_sys_i) disable iff (rst_i)
      (ph == ext_bus_pkg::PH_LAST && !power_down_i && !idle_i && !data_req_i.valid &&
       kind_ff != ext_bus_pkg::SLOT_DATA1 && external_access_select_i &&
       pc_i <= ext_bus_pkg::INT_ROM_TOP) |=> kind_ff == ext_bus_pkg::SLOT_INT_FETCH;
  endproperty
  a_int_fetch: assert property (p_int_fetch) else $error("low fetch not internal"); // see RL6

  property p_ext_fetch;
    @(posedge clk_sys_i) disable iff (rst_i)
      (ph == ext_bus_pkg::PH_LAST && !power_down_i && !idle_i && !data_req_i.valid &&
       kind_ff != ext_bus_pkg::SLOT_DATA1 && !external_access_select_i)
      |=> kind_ff == ext_bus_pkg::SLOT_FETCH;
  endproperty
  a_ext_fetch: assert property (p_ext_fetch) else $error("fetch not external"); // see RL7

  property p_mux_write;
    @(posedge clk_sys_i) disable iff (rst_i || power_down_i)
      (kind_ff == ext_bus_pkg::SLOT_DATA2 && ph == ext_bus_pkg::PH_FIRST && acc_ff.write) |->
      low_address_data_bus_o == acc_ff.addr[7:0] && low_address_data_bus_oe_o == 8'hFF
      ##3 low_address_data_bus_o == acc_ff.wdata && !ext_write_n_o;
  endproperty
  a_mux_write: assert property (p_mux_write) else $error("address then data broken"); // see RL8 RL9

  property p_read_float;
    @(posedge clk_sys_i) disable iff (rst_i || power_down_i)
      !ext_read_n_o |-> low_address_data_bus_oe_o == 8'h00;
  endproperty
  a_read_float: assert property (p_read_float) else $error("bus driven during read"); // see RL15

  property p_high_wide;
    @(posedge clk_sys_i) disable iff (rst_i || power_down_i)
      (kind_ff == ext_bus_pkg::SLOT_FETCH ||
       (kind_ff == ext_bus_pkg::SLOT_DATA2 && acc_ff.wide))
      |-> high_address_bus_o == acc_ff.addr[15:8];
  endproperty
  a_high_wide: assert property (p_high_wide) else $error("high address missing"); // see RL13

  property p_high_narrow;
    @(posedge clk_sys_i) disable iff (rst_i || power_down_i)
      (kind_ff == ext_bus_pkg::SLOT_DATA2 && !acc_ff.wide && !$past(power_down_i))
      |-> high_address_bus_o == $past(high_address_port_latch_i);
  endproperty
  a_high_narrow: assert property (p_high_narrow) else $error("latch not kept"); // see RL14

  property p_gpio_float;
    @(posedge clk_sys_i) disable iff (rst_i)
      (kind_ff == ext_bus_pkg::SLOT_INT_FETCH && $past(kind_ff) == ext_bus_pkg::SLOT_INT_FETCH)
      |-> low_address_data_bus_oe_o == ~$past(low_port_latch_i);
  endproperty
  a_gpio_float: assert property (p_gpio_float) else $error("latch one bit driven"); // see RL10

  property p_idle;
    @(posedge clk_sys_i) disable iff (rst_i)
      (idle_i && !power_down_i && ph == ext_bus_pkg::PH_LAST &&
       kind_ff != ext_bus_pkg::SLOT_DATA1) |=> kind_ff == ext_bus_pkg::SLOT_IO ##1 !fetch_resp_o.done;
  endproperty
  a_idle: assert property (p_idle) else $error("activity during idle"); // see RL11

  property p_power_down;
    @(posedge clk_sys_i) disable iff (rst_i)
      power_down_i |=> !ale_o && program_fetch_strobe_n_o && cnt_ff == $past(cnt_ff);
  endproperty
  a_power_down: assert property (p_power_down) else $error("activity in power-down"); // see RL12

endmodule // ext_bus_seq

/* dv/ext_mem_model.sv */
// Behavioural external memory with address latch on the multiplexed bus
`timescale 1ns/100ps
module ext_mem_model (
  input  wire logic       clk_i,
  input  wire logic       ale_i,
  input  wire logic       fetch_stb_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [7:0] high_i,
  input  wire logic [7:0] dut_out_i,
  input  wire logic [7:0] dut_oe_i,
  output logic      [7:0] pin_o
);
  logic [7:0] lat_ff = 8'h00;
  logic [7:0] flt_ff = 8'h00;
  logic [7:0] mem [0:65535];
  logic [7:0] drv;
  logic       drv_en;
  // Low address taken as the strobe falls, while the address still stands
  always @(negedge ale_i) lat_ff <= pin_o;
  always_comb begin
    drv_en = !fetch_stb_n_i || !rd_n_i;
    drv    = !fetch_stb_n_i ? (lat_ff ^ high_i ^ 8'hA5) : mem[{high_i, lat_ff}];
    for (int i = 0; i < 8; i++) begin
      pin_o[i] = dut_oe_i[i] ? dut_out_i[i] : (drv_en ? drv[i] : flt_ff[i]);
    end
  end
  // Floating lines show the inverse of the last level, so stale data never passes
  always @(posedge clk_i) begin
    flt_ff <= ~pin_o;
    if (!wr_n_i) mem[{high_i, lat_ff}] <= pin_o;
  end
endmodule // ext_mem_model

/* dv/tb_ext_bus_seq.sv */
// Self-checking bench for the external memory bus sequencer
`timescale 1ns/100ps
module tb_ext_bus_seq;
  logic                     clk_sys_i = 1'b0;
  logic                     rst_i     = 1'b1;
  logic                     sel       = 1'b0;
  logic                     idle      = 1'b0;
  logic                     pdn       = 1'b0;
  logic [15:0]              pc        = 16'h8000;
  logic [7:0]               lo_latch  = 8'hFF;
  logic [7:0]               hi_latch  = 8'h9A;
  ext_bus_pkg::data_req_t   req       = '0;
  ext_bus_pkg::fetch_resp_t fr;
  ext_bus_pkg::data_resp_t  dr;
  logic [7:0]               pin, bus_out, bus_oe, hi_bus;
  logic                     ale, fetch_stb_n, rd_n, wr_n, ale_q;
  logic [2:0]               st;
  int                       err_total, check_count, cyc, ale_rise, ale_hi, stb_low, dones;

  always #50 clk_sys_i = ~clk_sys_i;

  ext_bus_seq i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .external_access_select_i(sel),
    .idle_i(idle), .power_down_i(pdn), .pc_i(pc), .data_req_i(req),
    .low_port_latch_i(lo_latch), .high_address_port_latch_i(hi_latch),
    .low_address_data_bus_i(pin), .low_address_data_bus_o(bus_out),
    .low_address_data_bus_oe_o(bus_oe), .high_address_bus_o(hi_bus), .ale_o(ale),
    .program_fetch_strobe_n_o(fetch_stb_n), .ext_read_n_o(rd_n), .ext_write_n_o(wr_n),
    .state_idx_o(st), .fetch_resp_o(fr), .data_resp_o(dr));

  ext_mem_model i_mem (.clk_i(clk_sys_i), .ale_i(ale), .fetch_stb_n_i(fetch_stb_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .high_i(hi_bus), .dut_out_i(bus_out), .dut_oe_i(bus_oe), .pin_o(pin));

  // Counters sampled mid-cycle, cleared just after a rising edge, so they never race
  always @(negedge clk_sys_i) begin
    if (ale === 1'b1 && ale_q !== 1'b1) ale_rise++;
    if (ale === 1'b1) ale_hi++;
    if (fetch_stb_n === 1'b0) stb_low++;
    if (fr.done === 1'b1 || dr.done === 1'b1) dones++;
    ale_q = ale;
  end

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      #1;
    end
  endtask

  task automatic clr();
    ale_rise = 0;
    ale_hi = 0;
    stb_low = 0;
    dones = 0;
  endtask

  task automatic t_timing();
    int k;
    for (k = 0; k < 20 && st !== 3'h5; k++) @(negedge clk_sys_i);
    for (k = 0; k < 20 && st === 3'h5; k++) @(negedge clk_sys_i);
    for (k = 0; k < 12; k++) begin
      chk(16'(st), 16'(k / 2));
      @(negedge clk_sys_i);
    end
    step(1);
    clr();
    step(60);
    chk(16'(ale_rise), 16'h000A);
    chk(16'(ale_hi), 16'h0014);
  endtask

  task automatic fetch_one(input logic [15:0] a, input logic ext);
    ext_bus_pkg::fetch_resp_t r;
    int k;
    r = '0;
    pc = a;
    step(12);
    clr();
    step(12);
    chk(16'(stb_low), ext ? 16'h0004 : 16'h0000);
    if (ext) begin
      for (k = 0; k < 8 && ale !== 1'b1; k++) @(negedge clk_sys_i);
      chk({bus_oe, bus_out}, {8'hFF, a[7:0]});
      chk(16'(hi_bus), 16'(a[15:8]));
    end
    for (k = 0; k < 8 && r.done !== 1'b1; k++) begin
      @(negedge clk_sys_i);
      r = fr;
    end
    chk(16'(r.done), 16'h0001);
    chk(16'(r.ext), 16'(ext));
    if (ext) chk(16'(r.code), 16'(a[7:0] ^ a[15:8] ^ 8'hA5));
    step(1);
  endtask

  task automatic t_fetch();
    sel = 1'b0;
    fetch_one(16'h12B4, 1'b1);
    fetch_one(16'h0100, 1'b1);
    sel = 1'b1;
    fetch_one(16'h3FFF, 1'b0);
    fetch_one(16'h4000, 1'b1);
    sel = 1'b0;
  endtask

  task automatic data_op(input logic w, input logic wd, input logic [15:0] a,
                         input logic [7:0] d, output logic [7:0] rdat, output logic [7:0] hi,
                         output logic [7:0] oe, output logic [7:0] lo);
    logic got;
    got = 1'b0;
    {rdat, hi, oe, lo} = '0;
    req = '{1'b1, w, wd, a, d};
    clr();
    // Fixed window of six slots, so the replaced fetch strobes can be counted
    repeat (36) begin
      @(negedge clk_sys_i);
      if (rd_n === 1'b0 || wr_n === 1'b0) {hi, oe, lo} = {hi_bus, bus_oe, bus_out};
      if (dr.done === 1'b1) begin
        got = 1'b1;
        rdat = dr.rdata;
      end
      step(1);
      if (got) req.valid = 1'b0;
    end
    chk(16'(got), 16'h0001);
    chk(16'(stb_low), 16'h0008);
  endtask

  task automatic t_data();
    logic [7:0] rd, hi, oe, lo;
    pc = 16'h8000;
    step(12);
    data_op(1'b1, 1'b1, 16'h5678, 8'hC3, rd, hi, oe, lo);
    chk(16'(hi), 16'h0056);
    chk({oe, lo}, 16'hFFC3);
    data_op(1'b0, 1'b1, 16'h5678, 8'h00, rd, hi, oe, lo);
    chk(16'(rd), 16'h00C3);
    chk({hi, oe}, 16'h5600);
    data_op(1'b1, 1'b0, 16'h0012, 8'h3C, rd, hi, oe, lo);
    chk(16'(hi), 16'h009A);
    data_op(1'b0, 1'b0, 16'h0012, 8'h00, rd, hi, oe, lo);
    chk({hi, rd}, 16'h9A3C);
  endtask

  task automatic t_power();
    idle = 1'b1;
    step(12);
    clr();
    step(24);
    chk(16'(ale_rise), 16'h0004);
    chk(16'(stb_low + dones), 16'h0000);
    idle = 1'b0;
    lo_latch = 8'h5A;
    pdn = 1'b1;
    step(12);
    clr();
    step(24);
    chk(16'(ale_hi + stb_low + dones), 16'h0000);
    chk(16'(bus_oe), 16'h00A5);
    pdn = 1'b0;
    step(12);
  endtask

  initial begin
    step(4);
    rst_i = 1'b0;
    t_timing();
    t_fetch();
    t_data();
    t_power();
    give_verdict();
  end
endmodule // tb_ext_bus_seq
